// ### dv/rfs_checker.sv
// link checker: assertions on the host-to-bank register link
// assumes instantiation beside the link interface on the same sys_clk and rst
`timescale 1ns/100ps
`default_nettype none
module rfs_checker (
  input wire logic       sys_clk,        // clock
  input wire logic       rst,            // sync reset
  input wire logic       cs_n,           // select
  input wire logic       req,            // request
  input wire logic       wr,             // write
  input wire logic [3:0] addr,           // index
  input wire logic [7:0] wdata,          // write data
  input wire logic [7:0] rdata,          // read data
  input wire logic       ack,            // answer
  input wire logic       enable_pin,     // enable pin
  input wire logic       aux_output_pin  // aux output
);
  logic [5:0] ctl_m;
  logic [2:0] sel_m;
  logic       tx_m;
  logic       en_m;
  logic       pin_q;
  // mirror of bank registers, one cycle behind the bank
  wire        blk = ctl_m[5] & ~(en_m | pin_q);
  wire        upd = ack & wr & ~blk;
  always_ff @(posedge sys_clk) begin
    pin_q <= enable_pin;
    if (rst) begin
      ctl_m <= 6'h00;
      sel_m <= 3'h0;
      tx_m  <= 1'b0;
      en_m  <= 1'b0;
    end else if (upd) begin
      if (addr == 4'h0) ctl_m <= wdata[5:0];
      if (addr == 4'h7) tx_m <= wdata[0];
      if (addr == 4'h8) en_m <= wdata[0];
      if (addr == 4'h9) sel_m <= wdata[2:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 !ack;
  endsequence
  AST_ACK_TIMING: assert property (s_take |=> s_answer)
    else $error("ack not a single pulse one cycle after request");
  AST_REQ_DROP: assert property (ack |=> !req)
    else $error("request held after ack");
  AST_REQ_SELECT: assert property (req |-> !cs_n)
    else $error("request without select");
  AST_RANGE_READ: assert property (ack && !wr && addr >= 4'hA |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_BLOCK_READ: assert property (ack && !wr && blk |-> rdata == 8'h00)
    else $error("read in blocked shutdown not zero");
  AST_SEL_READ: assert property (ack && !wr && !blk && addr == 4'h9 |-> rdata == {5'h00, sel_m})
    else $error("selector readback wrong");
  AST_AUX_BIT: assert property (sel_m == 3'h7 |-> aux_output_pin == tx_m)
    else $error("aux pin not the data bit");
  AST_AUX_READBACK: assert property (sel_m == 3'h1 |-> aux_output_pin == $past(rdata[0]))
    else $error("aux pin not readback");
  AST_AUX_CSLOW: assert property (sel_m == 3'h0 && $past(cs_n) == 1'b0
                                  |-> aux_output_pin == $past(rdata[0]))
    else $error("aux pin not readback while selected");
  AST_RSVD_ZERO: assert property (req && wr && addr == 4'h9 |-> !(|wdata[7:3]))
    else $error("reserved selector bits written nonzero");
  AST_AUX_RESERVED: assert property (sel_m == 3'h3 || sel_m == 3'h4 |-> !aux_output_pin)
    else $error("aux pin high on unused code");
  AST_CLOCK_OFF: assert property ((sel_m == 3'h2 && !ctl_m[1]) [*4] |-> !aux_output_pin)
    else $error("clock on aux pin while disabled");
endmodule // rfs_checker
`default_nettype wire

// ### dv/tb_top.sv
// testbench: host controller and register bank joined by the link interface
// assumes software access over Avalon-MM; all link traffic goes through the host
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin \
  samples_checked++; \
  if ((a) !== (e)) begin \
    num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); \
  end \
end
module tb_top;
  localparam int         LD = 40;
  localparam logic [3:0] TA [8] = '{4'h8, 4'h7, 4'h9, 4'h0, 4'h1, 4'h2, 4'h6, 4'hA};
  localparam logic [7:0] TW [8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hB5, 8'hA7, 8'h00, 8'hFF};
  localparam logic [7:0] TR [8] = '{8'h01, 8'h01, 8'h07, 8'h3F, 8'hB5, 8'hA7, 8'h00, 8'h00};
  localparam logic [7:0] WD [8] = '{8'h2F, 8'h42, 8'hC0, 8'h5A, 8'h50, 8'h00, 8'h30, 8'h00};
  localparam logic [31:0] EW [2] = '{32'h2F42C05A, 32'h50003000};
  localparam logic [10:0] ER [2] = '{{5'h12, 5'h1C, 1'b1}, {5'h15, 5'h13, 1'b0}};
  localparam logic [7:0] AUXE = 8'hA0;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        osc_stop = 1'b0;
  logic        tx_rdy = 1'b0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire         mode_fsk, shape_on, pll_wide_bw, tx_data, tx_enable, sdr, load_busy, drc;
  wire  [4:0]  cap_sel, hi_ratio, lo_ratio;
  wire  [15:0] hi_word, lo_word;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          cnt;
  int          e;
  logic [31:0] q;
  logic [7:0]  v;

  rfs_link_if lnk ();
  rfs_bank #(.LOAD_CYC(LD)) i_rfs_bank (.sys_clk(sys_clk), .rst(rst), .link(lnk.dev),
    .oscillator_stopped(osc_stop), .transmitter_ready(tx_rdy), .mode_fsk(mode_fsk),
    .shape_on(shape_on), .pll_wide_bw(pll_wide_bw), .cap_sel(cap_sel), .tx_data(tx_data),
    .tx_enable(tx_enable), .hi_word(hi_word), .lo_word(lo_word), .hi_ratio(hi_ratio),
    .lo_ratio(lo_ratio), .sigma_delta_run(sdr), .load_busy(load_busy),
    .divided_ref_clock(drc));
  rfs_host i_rfs_host (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link(lnk.host));
  rfs_checker i_rfs_checker (.sys_clk(sys_clk), .rst(rst), .cs_n(lnk.cs_n), .req(lnk.req),
    .wr(lnk.wr), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack),
    .enable_pin(lnk.enable_pin), .aux_output_pin(lnk.aux_output_pin));

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  // one Avalon transfer, held until waitrequest is sampled low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  // one link access through the host, polled until idle; read data left in v
  task automatic lk(input logic w, input logic [3:0] a, input logic [7:0] d);
    av(1'b1, rfs_pkg::HO_CMD, {8'h00, d, 7'h00, w, 4'h0, a});
    q = 32'h1;
    while (q[rfs_pkg::ST_BUSY] !== 1'b0) av(1'b0, rfs_pkg::HO_STATUS, 32'h0);
    v = q[15:8];
  endtask

  // counts aux pin transitions over 128 cycles; a divided clock output unlike the pin adds 1000
  task automatic tog();
    logic p;
    p = lnk.aux_output_pin;
    cnt = 0;
    repeat (128) begin
      @(posedge sys_clk);
      if (lnk.aux_output_pin !== p) cnt++;
      if (drc !== lnk.aux_output_pin) cnt += 1000;
      p = lnk.aux_output_pin;
    end
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    `CHK({hi_ratio, load_busy}, 6'h20)
    for (int i = 0; i < 11; i++) begin
      lk(1'b0, 4'(i), 8'h00);
      `CHK(v, 8'h00)
    end
    for (int i = 0; i < 8; i++) begin
      lk(1'b1, TA[i], TW[i]);
      lk(1'b0, TA[i], 8'h00);
      `CHK(v, TR[i])
    end
    `CHK({mode_fsk, shape_on, pll_wide_bw, cap_sel}, 8'hF5)
    lk(1'b1, 4'h0, 8'h00);
    `CHK({mode_fsk, shape_on, pll_wide_bw}, 3'h0)
    osc_stop <= 1'b1;
    for (int i = 3; i < 8; i++) begin
      lk(1'b1, 4'h9, 8'(i));
      repeat (4) @(posedge sys_clk);
      av(1'b0, rfs_pkg::HO_STATUS, 32'h0);
      `CHK({lnk.aux_output_pin, q[rfs_pkg::ST_AUX]}, {2{AUXE[i]}})
    end
    lk(1'b1, 4'h9, 8'h01);
    lk(1'b0, 4'h9, 8'h00);
    `CHK(lnk.aux_output_pin, 1'b1)
    lk(1'b0, 4'h0, 8'h00);
    `CHK(lnk.aux_output_pin, 1'b0)
    // only one source of data and enable is high at a time
    for (int i = 0; i < 3; i++) begin
      av(1'b1, rfs_pkg::HO_PINS, {30'h0, {2{i[0]}}});
      lk(1'b1, 4'h7, {7'h00, i[1]});
      lk(1'b1, 4'h8, {7'h00, i[1]});
      `CHK({tx_data, tx_enable}, {2{i[0] | i[1]}})
    end
    lk(1'b1, 4'h0, 8'h02);
    lk(1'b1, 4'h9, 8'h02);
    for (int i = 0; i < 8; i++) begin
      lk(1'b1, 4'h1, {i[2:0], 5'h00});
      repeat (40) @(posedge sys_clk);
      tog();
      e = i[2] ? 8 : (128 >> i);
      `CHK(cnt >= e - 1 && cnt <= e + 1, 1'b1)
    end
    lk(1'b1, 4'h8, 8'h00);
    repeat (40) @(posedge sys_clk);
    tog();
    `CHK({cnt, lnk.aux_output_pin}, {32'd0, 1'b0})
    lk(1'b1, 4'h0, 8'h06);
    repeat (40) @(posedge sys_clk);
    tog();
    `CHK(cnt >= 7 && cnt <= 9, 1'b1)
    lk(1'b1, 4'h0, 8'h04);
    repeat (40) @(posedge sys_clk);
    tog();
    `CHK(cnt, 0)
    lk(1'b1, 4'h8, 8'h01);
    lk(1'b1, 4'h0, 8'h20);
    lk(1'b1, 4'h8, 8'h00);
    lk(1'b1, 4'h9, 8'h03);
    lk(1'b0, 4'h9, 8'h00);
    `CHK(v, 8'h00)
    av(1'b1, rfs_pkg::HO_PINS, 32'h2);
    lk(1'b0, 4'h9, 8'h00);
    `CHK(v, 8'h02)
    // words stay inside the modulator limits
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) lk(1'b1, 4'(i + 2), WD[j * 4 + i]);
      `CHK(hi_word, (j == 0) ? 16'h0000 : 16'h2F42)
      lk(1'b1, 4'h6, 8'h01);
      lk(1'b0, 4'h6, 8'h00);
      `CHK(v, 8'h01)
      while (load_busy !== 1'b0) @(posedge sys_clk);
      `CHK({hi_word, lo_word}, EW[j])
      `CHK({hi_ratio, lo_ratio, sdr}, ER[j])
      lk(1'b0, 4'h6, 8'h00);
      `CHK(v, 8'h00)
    end
    // selector 0 with the link idle shows the divided clock
    lk(1'b1, 4'h0, 8'h22);
    lk(1'b1, 4'h9, 8'h00);
    repeat (40) @(posedge sys_clk);
    tog();
    `CHK(cnt >= 7 && cnt <= 9, 1'b1)
    end_sim();
  end
endmodule // tb_top
`default_nettype wire

// ### inc/rfs_link_if.sv
// register link and pins between the host controller and the transmitter register bank
// assumes both ends run on the same sys_clk
`timescale 1ns/100ps
`default_nettype none
interface rfs_link_if;
  logic                       cs_n;
  logic                       req;
  logic                       wr;
  logic [rfs_pkg::ADDR_W-1:0] addr;
  logic [rfs_pkg::DATA_W-1:0] wdata;
  logic [rfs_pkg::DATA_W-1:0] rdata;
  logic                       ack;
  logic                       din_pin;
  logic                       enable_pin;
  logic                       aux_output_pin;

  modport dev  (input cs_n, req, wr, addr, wdata, din_pin, enable_pin,
                output rdata, ack, aux_output_pin);
  modport host (output cs_n, req, wr, addr, wdata, din_pin, enable_pin,
                input rdata, ack, aux_output_pin);
endinterface
`default_nettype wire

// ### inc/rfs_pkg.sv
// constants shared by the transmitter register bank, its host and the link between them
// assumes one 40 MHz system clock on both ends
package rfs_pkg;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 8;
  localparam int NUM_REGS = 10;
  localparam int WORD_W   = 16;
  localparam int INT_LSB  = 12;
  localparam int FRAC_W   = 12;
  localparam int RATIO_W  = 5;

  // device register indices
  localparam logic [3:0] REG_MAIN    = 4'h0;
  localparam logic [3:0] REG_TUNE    = 4'h1;
  localparam logic [3:0] REG_HI_UP   = 4'h2;
  localparam logic [3:0] REG_HI_LO   = 4'h3;
  localparam logic [3:0] REG_LO_UP   = 4'h4;
  localparam logic [3:0] REG_LO_LO   = 4'h5;
  localparam logic [3:0] REG_APPLY   = 4'h6;
  localparam logic [3:0] REG_TX_BIT  = 4'h7;
  localparam logic [3:0] REG_PWR_ON  = 4'h8;
  localparam logic [3:0] REG_AUX_CFG = 4'h9;

  // main_control fields
  localparam int MC_MODE      = 0;
  localparam int MC_CLK_ON    = 1;
  localparam int MC_CLK_SHD   = 2;
  localparam int MC_SHAPE     = 3;
  localparam int MC_PLLBW     = 4;
  localparam int MC_SPI_OFF   = 5;

  // tuning_and_clock_divide fields
  localparam int CAP_LSB   = 0;
  localparam int CAP_W     = 5;
  localparam int CKDIV_LSB = 5;
  localparam int CKDIV_W   = 3;
  localparam int SEL_W     = 3;

  // writable bits and reset value of each register
  localparam logic [7:0] WMASK [NUM_REGS] = '{8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                              8'hFF, 8'h00, 8'h01, 8'h01, 8'h07};
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] INT_OFFSET = 5'h10;

  // aux_output_pin selector codes
  localparam logic [2:0] AUX_CLK_OR_RB = 3'h0;
  localparam logic [2:0] AUX_READBACK  = 3'h1;
  localparam logic [2:0] AUX_CLOCK     = 3'h2;
  localparam logic [2:0] AUX_OSC_STOP  = 3'h5;
  localparam logic [2:0] AUX_TX_READY  = 3'h6;
  localparam logic [2:0] AUX_TX_BIT    = 3'h7;

  // frequency load duration
  localparam int CLK_PERIOD_NS = 25;
  localparam int LOAD_TIME_NS  = 100;
  localparam int LOAD_CYCLES   = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // host-side Avalon registers (byte offsets)
  localparam logic [3:0] HO_CMD    = 4'h0;
  localparam logic [3:0] HO_STATUS = 4'h4;
  localparam logic [3:0] HO_PINS   = 4'h8;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_WR       = 8;
  localparam int CMD_DATA_LSB = 16;
  localparam int ST_BUSY      = 0;
  localparam int ST_AUX       = 1;
  localparam int ST_RDATA_LSB = 8;
  localparam int PIN_DIN      = 0;
  localparam int PIN_EN       = 1;
endpackage

// ### verilog/rfs_bank.sv
// transmitter control register bank: device end of the register link
// assumes host logic on the same sys_clk; analogue status inputs are asynchronous
//
// What this block does
// - mode bit: 0 amplitude keying, 1 frequency keying
// - bit 1 puts crystal clock on aux pin
// - bit 2 keeps clock output alive in shutdown
// - bit 3 switches envelope shaping resistor
// - bit 4 picks 300kHz or 600kHz loop bandwidth
// - bit 5 set blocks register access in shutdown
// - five low bits pick shunt capacitance
// - divider codes give 2,4,8,16,32 division of sys_clk
// - high word: 4-bit integer, 12-bit fraction
// - low word same layout, carrier in amplitude
// - sixteen added to integer part
// - host keeps words inside modulator limits
// - zero fractions stop the delta-sigma modulator
// - load bit applies words to synthesizer
// - load bit clears itself when done
// - data bit substitutes the data pin
// - host uses only one data source
// - enable bit substitutes the enable pin
// - host uses only one enable source
// - selector codes map clock, readback, status
// - host writes zero to reserved bits; rfs_host forces only the selector's bits 7:3 to zero
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module rfs_bank #(
  parameter int LOAD_CYC = rfs_pkg::LOAD_CYCLES
) (
  input  wire logic                             sys_clk,            // 40 MHz clock
  input  wire logic                             rst,                // sync reset, high
  rfs_link_if.dev                               link,               // register link and pins
  input  wire logic                             oscillator_stopped, // async analogue status
  input  wire logic                             transmitter_ready,  // async analogue status
  output wire logic                             mode_fsk,           // 1 frequency keying
  output wire logic                             shape_on,           // shaping resistor in
  output wire logic                             pll_wide_bw,        // 1 = 600kHz loop
  output wire logic [rfs_pkg::CAP_W-1:0]        cap_sel,            // shunt capacitance level
  output logic                                  tx_data,            // transmitted data
  output logic                                  tx_enable,          // transmitter enabled
  output logic      [rfs_pkg::WORD_W-1:0]       hi_word,            // active high-tone word
  output logic      [rfs_pkg::WORD_W-1:0]       lo_word,            // active low-tone word
  output logic      [rfs_pkg::RATIO_W-1:0]      hi_ratio,           // high integer ratio
  output logic      [rfs_pkg::RATIO_W-1:0]      lo_ratio,           // low integer ratio
  output logic                                  sigma_delta_run,    // modulator running
  output logic                                  load_busy,          // frequency load pending
  output logic                                  divided_ref_clock   // gated divided clock
);
  if (LOAD_CYC < 1 || LOAD_CYC > 255) begin : g_bad_load
    $error("rfs_bank: LOAD_CYC out of range");
  end

  logic [7:0] regs [rfs_pkg::NUM_REGS];
  logic       osc_meta, osc_sync, rdy_meta, rdy_sync;
  logic       ack_q;
  logic [7:0] rdata_q;
  logic       readback_bit;
  logic [7:0] load_cnt;
  logic       aux_q;
  logic       div_clk;

  // two-flop synchronisers for analogue status
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      rdy_meta <= 1'b0;
      rdy_sync <= 1'b0;
    end else begin
      osc_meta <= oscillator_stopped;
      osc_sync <= osc_meta;
      rdy_meta <= transmitter_ready;
      rdy_sync <= rdy_meta;
    end
  end

  wire shutdown  = ~tx_enable;
  wire blocked   = shutdown & regs[rfs_pkg::REG_MAIN][rfs_pkg::MC_SPI_OFF];
  wire accept    = link.req & ~ack_q;
  wire in_range  = (link.addr < rfs_pkg::ADDR_W'(rfs_pkg::NUM_REGS));
  wire wr_hit    = accept & link.wr & ~blocked & in_range;
  wire rd_hit    = accept & ~link.wr;
  wire load_req  = wr_hit & (link.addr == rfs_pkg::REG_APPLY) & link.wdata[0];
  wire load_done = load_busy & (load_cnt == 8'h01);

  function automatic logic [7:0] read_mux(input logic [3:0] a, input logic busy,
                                          input logic [7:0] v);
    if (a == rfs_pkg::REG_APPLY)
      read_mux = {7'h00, busy};
    else
      read_mux = v;
  endfunction

  wire [7:0] reg_value = in_range ? regs[link.addr] : 8'h00;
  wire [7:0] next_rdata = blocked ? 8'h00 : read_mux(link.addr, load_busy, reg_value);

  // storage, reserved bits masked so they read zero
  for (genvar i = 0; i < rfs_pkg::NUM_REGS; i++) begin : g_reg
    always_ff @(posedge sys_clk) begin
      if (rst)
        regs[i] <= rfs_pkg::REG_RESET;
      else if (wr_hit && link.addr == rfs_pkg::ADDR_W'(i))
        regs[i] <= link.wdata & rfs_pkg::WMASK[i];
    end
  end

  // link answer: one-cycle ack the edge after the request is taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q        <= 1'b0;
      rdata_q      <= 8'h00;
      readback_bit <= 1'b0;
    end else begin
      ack_q <= accept;
      if (rd_hit) begin
        rdata_q      <= next_rdata;
        readback_bit <= next_rdata[0];
      end
    end
  end

  wire [15:0] staged_hi = {regs[rfs_pkg::REG_HI_UP], regs[rfs_pkg::REG_HI_LO]};
  wire [15:0] staged_lo = {regs[rfs_pkg::REG_LO_UP], regs[rfs_pkg::REG_LO_LO]};
  wire [4:0]  next_hi_ratio = rfs_pkg::INT_OFFSET + {1'b0, staged_hi[15:12]};
  wire [4:0]  next_lo_ratio = rfs_pkg::INT_OFFSET + {1'b0, staged_lo[15:12]};
  wire        next_frac_run = |{staged_hi[11:0], staged_lo[11:0]};

  // frequency load: a new request restarts the count, so a set never loses to the clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      load_busy       <= 1'b0;
      load_cnt        <= 8'h00;
      hi_word         <= 16'h0000;
      lo_word         <= 16'h0000;
      hi_ratio        <= rfs_pkg::INT_OFFSET;
      lo_ratio        <= rfs_pkg::INT_OFFSET;
      sigma_delta_run <= 1'b0;
    end else if (load_req) begin
      load_busy <= 1'b1;
      load_cnt  <= 8'(LOAD_CYC);
    end else if (load_done) begin
      load_busy       <= 1'b0;
      load_cnt        <= 8'h00;
      hi_word         <= staged_hi;
      lo_word         <= staged_lo;
      hi_ratio        <= next_hi_ratio;
      lo_ratio        <= next_lo_ratio;
      sigma_delta_run <= next_frac_run;
    end else if (load_busy) begin
      load_cnt <= load_cnt - 8'h01;
    end
  end

  // pin and register sources combined
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_data   <= 1'b0;
      tx_enable <= 1'b0;
    end else begin
      tx_data   <= link.din_pin | regs[rfs_pkg::REG_TX_BIT][0];
      tx_enable <= link.enable_pin | regs[rfs_pkg::REG_PWR_ON][0];
    end
  end

  wire [7:0] mc      = regs[rfs_pkg::REG_MAIN];
  wire [7:0] tune    = regs[rfs_pkg::REG_TUNE];
  wire       clk_run = mc[rfs_pkg::MC_CLK_ON] &
                       (~shutdown | mc[rfs_pkg::MC_CLK_SHD]);

  rfs_clk_div #(.CNT_W(4)) u_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (clk_run),
    .code    (tune[rfs_pkg::CKDIV_LSB +: rfs_pkg::CKDIV_W]),
    .clk_out (div_clk)
  );

  assign mode_fsk    = mc[rfs_pkg::MC_MODE];
  assign shape_on    = mc[rfs_pkg::MC_SHAPE];
  assign pll_wide_bw = mc[rfs_pkg::MC_PLLBW];
  assign cap_sel     = tune[rfs_pkg::CAP_LSB +: rfs_pkg::CAP_W];

  wire [2:0] sel = regs[rfs_pkg::REG_AUX_CFG][2:0];
  wire next_aux =
    (sel == rfs_pkg::AUX_CLK_OR_RB) ? (link.cs_n ? div_clk : readback_bit) :
    (sel == rfs_pkg::AUX_READBACK)  ? readback_bit :
    (sel == rfs_pkg::AUX_CLOCK)     ? div_clk :
    (sel == rfs_pkg::AUX_OSC_STOP)  ? osc_sync :
    (sel == rfs_pkg::AUX_TX_READY)  ? rdy_sync :
    (sel == rfs_pkg::AUX_TX_BIT)    ? regs[rfs_pkg::REG_TX_BIT][0] : 1'b0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aux_q             <= 1'b0;
      divided_ref_clock <= 1'b0;
    end else begin
      aux_q             <= next_aux;
      divided_ref_clock <= div_clk;
    end
  end

  assign link.ack            = ack_q;
  assign link.rdata          = rdata_q;
  assign link.aux_output_pin = aux_q;
endmodule // rfs_bank
`default_nettype wire

// ### verilog/rfs_clk_div.sv
// divided crystal clock generator: square wave on sys_clk, half period 2**k cycles for code k up to 4, 16 cycles for codes 5 to 7
// assumes the code is stable or changes only between periods
`timescale 1ns/100ps
`default_nettype none
module rfs_clk_div #(
  parameter int CNT_W = 4
) (
  input  wire logic                           sys_clk,  // system clock
  input  wire logic                           rst,      // sync reset
  input  wire logic                           run,      // clock output enabled
  input  wire logic [rfs_pkg::CKDIV_W-1:0]    code,     // divider code
  output logic                                clk_out   // divided clock
);
  if (CNT_W < 4) begin : g_bad_width
    $error("rfs_clk_div: CNT_W must be at least 4");
  end

  logic [CNT_W-1:0] cnt;
  wire  [CNT_W-1:0] half = code[2] ? CNT_W'(15) : CNT_W'((1 << code[1:0]) - 1);
  wire              tick = (cnt >= half);

  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      cnt     <= '0;
      clk_out <= 1'b0;
    end else begin
      cnt     <= tick ? '0 : cnt + CNT_W'(1);
      clk_out <= tick ? ~clk_out : clk_out;
    end
  end
endmodule // rfs_clk_div
`default_nettype wire

// ### verilog/rfs_host.sv
// host controller: Avalon-MM slave turning software orders into register link accesses
// assumes the bank on the same sys_clk; one link access at a time
`timescale 1ns/100ps
`default_nettype none
module rfs_host (
  input  wire logic        sys_clk,           // 40 MHz clock
  input  wire logic        rst,               // sync reset, high
  input  wire logic [3:0]  avs_address,       // byte address
  input  wire logic        avs_read,          // read request
  input  wire logic        avs_write,         // write request
  input  wire logic [31:0] avs_writedata,     // write data
  input  wire logic [3:0]  avs_byteenable,    // byte lanes
  output logic      [31:0] avs_readdata,      // read data
  output logic             avs_waitrequest,   // stall
  rfs_link_if.host         link               // register link and pins
);
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_SEL = 2'b01, H_REQ = 2'b11, H_END = 2'b10} rfs_hstate_t;

  rfs_hstate_t state;
  logic [7:0]  last_rdata;
  logic        cs_n_q, req_q, wr_q, din_q, en_q;
  logic [3:0]  addr_q;
  logic [7:0]  wdata_q;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  wire [31:0] m       = lane_mask(avs_byteenable);
  wire        busy    = (state != H_IDLE);
  wire        is_cmd  = (avs_address == rfs_pkg::HO_CMD);
  wire        is_pins = (avs_address == rfs_pkg::HO_PINS);
  wire        stall   = avs_write & is_cmd & busy;
  wire        take    = (avs_read | avs_write) & avs_waitrequest & ~stall;
  wire        start   = take & avs_write & is_cmd;
  wire [31:0] cmd_old = {8'h00, wdata_q, 7'h00, wr_q, 4'h0, addr_q};
  wire [31:0] cmd_new = (cmd_old & ~m) | (avs_writedata & m);
  wire [31:0] pin_new = ({30'h0, en_q, din_q} & ~m) | (avs_writedata & m);
  // reserved selector bits are forced to zero before they reach the link
  wire [7:0]  cmd_keep = (cmd_new[rfs_pkg::CMD_ADDR_LSB +: 4] == rfs_pkg::REG_AUX_CFG) ?
                         rfs_pkg::WMASK[rfs_pkg::REG_AUX_CFG] : 8'hFF;
  wire [31:0] next_rd =
    is_cmd ? cmd_old :
    (avs_address == rfs_pkg::HO_STATUS) ? {16'h0, last_rdata, 6'h0, link.aux_output_pin, busy} :
    is_pins ? {30'h0, en_q, din_q} : 32'h0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= ~take;
      avs_readdata    <= (take & avs_read) ? next_rd : avs_readdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      din_q    <= 1'b0;
      en_q     <= 1'b0;
    end else begin
      if (take && avs_write && is_pins) begin
        din_q <= pin_new[rfs_pkg::PIN_DIN];
        en_q  <= pin_new[rfs_pkg::PIN_EN];
      end
    end
  end

  // link sequence: select, hold request until ack, deselect
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state      <= H_IDLE;
      cs_n_q     <= 1'b1;
      req_q      <= 1'b0;
      wr_q       <= 1'b0;
      addr_q     <= 4'h0;
      wdata_q    <= 8'h00;
      last_rdata <= 8'h00;
    end else begin
      case (state)
        H_IDLE: begin
          if (start) begin
            addr_q  <= cmd_new[rfs_pkg::CMD_ADDR_LSB +: 4];
            wr_q    <= cmd_new[rfs_pkg::CMD_WR];
            wdata_q <= cmd_new[rfs_pkg::CMD_DATA_LSB +: 8] & cmd_keep;
            cs_n_q  <= 1'b0;
            state   <= H_SEL;
          end
        end
        H_SEL: begin
          req_q <= 1'b1;
          state <= H_REQ;
        end
        H_REQ: begin
          if (link.ack) begin
            req_q      <= 1'b0;
            last_rdata <= wr_q ? last_rdata : link.rdata;
            state      <= H_END;
          end
        end
        H_END: begin
          cs_n_q <= 1'b1;
          state  <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  assign link.cs_n       = cs_n_q;
  assign link.req        = req_q;
  assign link.wr         = wr_q;
  assign link.addr       = addr_q;
  assign link.wdata      = wdata_q;
  assign link.din_pin    = din_q;
  assign link.enable_pin = en_q;
endmodule // rfs_host
`default_nettype wire
